/* File: core/tbc_defs.svh */
// Constants for the sixteen-bit timer/counter: register offsets, reset values and timing counts.
// Assumes a single 250 MHz system clock and an 8-bit register port with one-cycle strobes.
//
// Overview of operation
// - The block holds a 16-bit count used as a timer or counter and flags an interrupt on every overflow.
// - Software reads and writes the count as a high byte and a low byte.
// - A special event trigger from a capture/compare unit clears the count.
// - With wide access on, the count is read and written as one 16-bit operation, otherwise as two 8-bit ones.
// - The clock-assignment field picks which timer pair clocks each capture/compare unit.
// - The prescale field divides the count clock by 1, 2, 4 or 8 before counting.
// - An external clock passes through a synchronizer unless sync-disable is set.
// - With the internal clock selected, sync-disable is ignored.
// - The external source counts rising edges after the first falling edge; the internal source is Fosc/4.
`ifndef TBC_DEFS_SVH
`define TBC_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define TBC_ADDR_W      3
`define TBC_OFF_CTRL    3'h0
`define TBC_OFF_CNT_LO  3'h1
`define TBC_OFF_CNT_HI  3'h2
`define TBC_OFF_STATUS  3'h3
`define TBC_OFF_MASK    3'h4

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define TBC_CTRL_RST    8'h00
`define TBC_CNT_RST     16'h0000
`define TBC_CNT_MAX     16'hffff
`define TBC_BYTE_RST    8'h00
`define TBC_ST_OVF      0
`define TBC_ASSIGN_ALL_B  2'h3
`define TBC_ASSIGN_SPLIT  2'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TBC_INT_DIV     4
`define TBC_INT_DIV_W   2
`define TBC_PS_W        3

`endif

/* File: core/tbc_pkg.sv */
// Types shared by the timer/counter files.
// Assumes tbc_defs.svh supplies the numeric constants.
package tbc_pkg;

	// Control register fields, most significant bit first.
	typedef struct packed {
		logic       wide_access_enable;
		logic       capture_clock_assign_hi;
		logic [1:0] prescale_select;
		logic       capture_clock_assign_lo;
		logic       sync_disable;
		logic       clock_source_select;
		logic       timer_on;
	} tbc_ctrl_s;

	// External edge qualifier: waits for the first falling edge.
	typedef enum logic [1:0] {
		TBC_ARM_WAIT  = 2'b01,
		TBC_ARM_READY = 2'b10
	} tbc_arm_e;

endpackage : tbc_pkg

/* File: core/tbc_prescale.sv */
// Prescaler for the timer/counter: passes one of every 1, 2, 4 or 8 input ticks.
// Assumes input ticks are one-cycle pulses on sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "tbc_defs.svh"

module tbc_prescale (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       tick_in,
	input  wire logic [1:0] select,
	input  wire logic       clear,
	output logic            tick_out
);

	logic [`TBC_PS_W-1:0] cnt_reg, cnt_next, limit;
	logic                 out_reg, out_next;

	// Terminal count per code: 00 none, 01 one, 10 three, 11 seven.
	always_comb begin
		limit = `TBC_PS_W'((1 << select) - 1);
		limit = (select == 2'h3) ? `TBC_PS_W'(7) : limit;
		cnt_next = cnt_reg;
		out_next = 1'b0;
		if (clear) begin
			cnt_next = '0;
		end else if (tick_in) begin
			if (cnt_reg >= limit) begin
				cnt_next = '0;
				out_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end

	// Registers only.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cnt_reg <= '0;
			out_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			out_reg <= out_next;
		end
	end

	assign tick_out = out_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_ps_div8;
		select == 2'h3 && !clear && tick_in && cnt_reg == 3'h7 |=> tick_out;
	endproperty
	a_ps_div8: assert property (p_ps_div8) else $error("Divide-by-8 tick missing.");

	property p_ps_cause;
		tick_out |-> $past(tick_in) && !$past(clear);
	endproperty
	a_ps_cause: assert property (p_ps_cause) else $error("Prescaler tick without input tick.");

endmodule : tbc_prescale
`default_nettype wire

/* File: core/tbc_timer.sv */
// Sixteen-bit timer/counter with control, count, interrupt status and mask registers.
// Assumes a register master with one-cycle strobes; the pin and trigger are synchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "tbc_defs.svh"

module tbc_timer #(
	parameter int CAPTURE_UNITS = 5
) (
	input  wire logic                   sys_clk,
	input  wire logic                   reset,
	input  wire logic [`TBC_ADDR_W-1:0] bus_addr,
	input  wire logic [7:0]             bus_wdata,
	input  wire logic                   bus_wr,
	input  wire logic                   bus_rd,
	output logic      [7:0]             bus_rdata,
	input  wire logic                   external_count_pin,
	input  wire logic                   special_event,
	output logic                        irq,
	output logic [CAPTURE_UNITS-1:0]    capture_use_b
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	// Unit 0 is the first enhanced unit; at least one other must follow it.
	if (CAPTURE_UNITS < 2) begin : g_bad_units
		$error("CAPTURE_UNITS must be at least 2.");
	end

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	tbc_pkg::tbc_ctrl_s             ctrl_reg, ctrl_next;
	logic [15:0]                    count_reg, count_next;
	logic [7:0]                     hi_buf_reg, hi_buf_next;
	logic [7:0]                     rdata_reg, rdata_next;
	logic [7:0]                     status_reg, status_next;
	logic [7:0]                     mask_reg, mask_next;
	logic                           irq_reg, irq_next;
	logic [CAPTURE_UNITS-1:0]       sel_reg, sel_next;
	logic [`TBC_INT_DIV_W-1:0]      div_reg, div_next;
	logic                           sync1_reg, sync2_reg;
	logic                           prev_reg, prev_next;
	tbc_pkg::tbc_arm_e              arm_reg, arm_next;
	logic                           int_tick, ext_level, ext_rise, ext_fall;
	logic                           src_tick, inc_tick, ps_clear, overflow;
	logic                           wr_ctrl, wr_lo, wr_hi, wr_st, wr_mask, rd_lo;

	// Decoded strobes.
	assign wr_ctrl = bus_wr && bus_addr == `TBC_OFF_CTRL;
	assign wr_lo   = bus_wr && bus_addr == `TBC_OFF_CNT_LO;
	assign wr_hi   = bus_wr && bus_addr == `TBC_OFF_CNT_HI;
	assign wr_st   = bus_wr && bus_addr == `TBC_OFF_STATUS;
	assign wr_mask = bus_wr && bus_addr == `TBC_OFF_MASK;
	assign rd_lo   = bus_rd && bus_addr == `TBC_OFF_CNT_LO;

	// ----------------------------------------------------------------
	// Clock sources
	// ----------------------------------------------------------------
	// Internal instruction clock: one enable pulse every fourth system clock.
	always_comb begin
		div_next = (div_reg == `TBC_INT_DIV_W'(`TBC_INT_DIV - 1)) ? '0 : div_reg + 1'b1;
		int_tick = (div_reg == `TBC_INT_DIV_W'(`TBC_INT_DIV - 1));
	end

	// Bypassing the synchronizer saves two cycles of latency but trusts the pin.
	always_comb begin
		ext_level = ctrl_reg.sync_disable ? external_count_pin : sync2_reg;
		prev_next = ext_level;
		ext_rise  = ext_level && !prev_reg;
		ext_fall  = !ext_level && prev_reg;
	end

	// Edge qualifier: a rising edge counts only once a falling edge was seen.
	always_comb begin
		arm_next = arm_reg;
		case (arm_reg)
			tbc_pkg::TBC_ARM_WAIT:  if (ext_fall) arm_next = tbc_pkg::TBC_ARM_READY;
			tbc_pkg::TBC_ARM_READY: arm_next = tbc_pkg::TBC_ARM_READY;
			default:                arm_next = tbc_pkg::TBC_ARM_WAIT;
		endcase
		if (!ctrl_reg.timer_on || !ctrl_reg.clock_source_select) begin
			arm_next = tbc_pkg::TBC_ARM_WAIT;
		end
	end

	// Source mux; the sync-disable bit has no effect on the internal path.
	always_comb begin
		if (ctrl_reg.clock_source_select) begin
			src_tick = (arm_reg == tbc_pkg::TBC_ARM_READY) && ext_rise;
		end else begin
			src_tick = int_tick;
		end
		src_tick = src_tick && ctrl_reg.timer_on;
		ps_clear = !ctrl_reg.timer_on || wr_ctrl || wr_lo;
	end

	tbc_prescale u_prescale (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.tick_in  (src_tick),
		.select   (ctrl_reg.prescale_select),
		.clear    (ps_clear),
		.tick_out (inc_tick)
	);

	// ----------------------------------------------------------------
	// Count and byte buffer
	// ----------------------------------------------------------------
	// Writes win over the trigger, the trigger over counting.
	always_comb begin
		count_next  = count_reg;
		hi_buf_next = hi_buf_reg;
		overflow    = 1'b0;
		if (wr_lo) begin
			if (ctrl_reg.wide_access_enable) begin
				count_next = {hi_buf_reg, bus_wdata};
			end else begin
				count_next[7:0] = bus_wdata;
			end
		end else if (wr_hi) begin
			if (ctrl_reg.wide_access_enable) begin
				hi_buf_next = bus_wdata;
			end else begin
				count_next[15:8] = bus_wdata;
			end
		end else if (special_event) begin
			count_next = `TBC_CNT_RST;
		end else if (inc_tick && ctrl_reg.timer_on) begin
			count_next = count_reg + 1'b1;
			overflow   = (count_reg == `TBC_CNT_MAX);
		end
		// A wide read of the low byte snapshots the high byte.
		if (rd_lo && ctrl_reg.wide_access_enable) begin
			hi_buf_next = count_reg[15:8];
		end
	end

	// ----------------------------------------------------------------
	// Control, interrupt and capture clock assignment
	// ----------------------------------------------------------------
	// Overflow set wins over a write-one clear in the same cycle.
	always_comb begin
		ctrl_next   = wr_ctrl ? tbc_pkg::tbc_ctrl_s'(bus_wdata) : ctrl_reg;
		mask_next   = wr_mask ? bus_wdata : mask_reg;
		status_next = wr_st ? (status_reg & ~bus_wdata) : status_reg;
		if (overflow) begin
			status_next[`TBC_ST_OVF] = 1'b1;
		end
		irq_next = |(status_next & mask_next);
	end

	// Per unit: 1 means the unit takes its time base from the second timer pair.
	for (genvar u = 0; u < CAPTURE_UNITS; u++) begin : g_assign
		always_comb begin
			case ({ctrl_next.capture_clock_assign_hi, ctrl_next.capture_clock_assign_lo})
				`TBC_ASSIGN_ALL_B: sel_next[u] = 1'b1;
				`TBC_ASSIGN_SPLIT: sel_next[u] = (u != 0);
				default:           sel_next[u] = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Unmapped addresses read as zero; data stands one cycle after the strobe.
	always_comb begin
		rdata_next = `TBC_BYTE_RST;
		if (bus_rd) begin
			case (bus_addr)
				`TBC_OFF_CTRL:   rdata_next = ctrl_reg;
				`TBC_OFF_CNT_LO: rdata_next = count_reg[7:0];
				`TBC_OFF_CNT_HI: rdata_next = ctrl_reg.wide_access_enable ? hi_buf_reg : count_reg[15:8];
				`TBC_OFF_STATUS: rdata_next = status_reg;
				`TBC_OFF_MASK:   rdata_next = mask_reg;
				default:         rdata_next = `TBC_BYTE_RST;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	// The first synchronizer stage feeds only the second.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctrl_reg   <= tbc_pkg::tbc_ctrl_s'(`TBC_CTRL_RST);
			count_reg  <= `TBC_CNT_RST;
			hi_buf_reg <= `TBC_BYTE_RST;
			rdata_reg  <= `TBC_BYTE_RST;
			status_reg <= `TBC_BYTE_RST;
			mask_reg   <= `TBC_BYTE_RST;
			irq_reg    <= 1'b0;
			sel_reg    <= '0;
			div_reg    <= '0;
			sync1_reg  <= 1'b0;
			sync2_reg  <= 1'b0;
			prev_reg   <= 1'b0;
			arm_reg    <= tbc_pkg::TBC_ARM_WAIT;
		end else begin
			ctrl_reg   <= ctrl_next;
			count_reg  <= count_next;
			hi_buf_reg <= hi_buf_next;
			rdata_reg  <= rdata_next;
			status_reg <= status_next;
			mask_reg   <= mask_next;
			irq_reg    <= irq_next;
			sel_reg    <= sel_next;
			div_reg    <= div_next;
			sync1_reg  <= external_count_pin;
			sync2_reg  <= sync1_reg;
			prev_reg   <= prev_next;
			arm_reg    <= arm_next;
		end
	end

	assign bus_rdata     = rdata_reg;
	assign irq           = irq_reg;
	assign capture_use_b = sel_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_ovf_flag;
		count_reg == `TBC_CNT_MAX && inc_tick && ctrl_reg.timer_on && !bus_wr && !special_event
			|=> status_reg[`TBC_ST_OVF] && count_reg == `TBC_CNT_RST;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("Overflow did not set the flag.");

	property p_irq_level;
		irq == |(status_reg & mask_reg);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("Interrupt disagrees with status and mask.");

	property p_split_hi;
		wr_hi && !ctrl_reg.wide_access_enable |=> count_reg[15:8] == $past(bus_wdata);
	endproperty
	a_split_hi: assert property (p_split_hi) else $error("Split high write lost.");

	property p_trigger;
		special_event && !wr_lo && !wr_hi |=> count_reg == `TBC_CNT_RST;
	endproperty
	a_trigger: assert property (p_trigger) else $error("Trigger did not clear the count.");

	property p_wide_wr;
		wr_lo && ctrl_reg.wide_access_enable |=> count_reg == {$past(hi_buf_reg), $past(bus_wdata)};
	endproperty
	a_wide_wr: assert property (p_wide_wr) else $error("Wide write not atomic.");

	property p_assign_split;
		wr_ctrl && !ctrl_next.capture_clock_assign_hi && ctrl_next.capture_clock_assign_lo
			|=> capture_use_b[0] == 1'b0 && capture_use_b[1];
	endproperty
	a_assign_split: assert property (p_assign_split) else $error("Split clock assignment wrong.");

	property p_sync_path;
		ctrl_reg.clock_source_select && !ctrl_reg.sync_disable |-> ext_level == $past(external_count_pin, 2);
	endproperty
	a_sync_path: assert property (p_sync_path) else $error("Synchronizer path latency wrong.");

	property p_internal;
		ctrl_reg.timer_on && !ctrl_reg.clock_source_select && int_tick |=> !int_tick [*3] ##1 int_tick;
	endproperty
	a_internal: assert property (p_internal) else $error("Internal clock not Fosc/4.");

	property p_first_fall;
		arm_reg == tbc_pkg::TBC_ARM_WAIT |-> !src_tick || !ctrl_reg.clock_source_select;
	endproperty
	a_first_fall: assert property (p_first_fall) else $error("Edge counted before first fall.");

	property p_hold_off;
		!ctrl_reg.timer_on && !wr_lo && !wr_hi && !special_event |=> count_reg == $past(count_reg);
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("Count moved while stopped.");

	// Byte access, shared buffer, read data timing, clock assignment, sources, counting and the overflow flag.
	property p_split_lo;
		wr_lo && !ctrl_reg.wide_access_enable |=> count_reg == {$past(count_reg[15:8]), $past(bus_wdata)};
	endproperty
	a_split_lo: assert property (p_split_lo) else $error("Split low write lost.");

	property p_rd_lo_data;
		rd_lo |=> bus_rdata == $past(count_reg[7:0]);
	endproperty
	a_rd_lo_data: assert property (p_rd_lo_data) else $error("Low byte read data wrong.");

	property p_rd_idle;
		!bus_rd |=> bus_rdata == `TBC_BYTE_RST;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("Read data stood past its cycle.");

	property p_wide_hi_buf;
		wr_hi && ctrl_reg.wide_access_enable |=> count_reg == $past(count_reg) && hi_buf_reg == $past(bus_wdata);
	endproperty
	a_wide_hi_buf: assert property (p_wide_hi_buf) else $error("Wide high write reached the count.");

	property p_wide_rd_snap;
		rd_lo && ctrl_reg.wide_access_enable |=> hi_buf_reg == $past(count_reg[15:8]);
	endproperty
	a_wide_rd_snap: assert property (p_wide_rd_snap) else $error("Wide read did not snapshot.");

	property p_assign_all;
		wr_ctrl && ctrl_next.capture_clock_assign_hi && ctrl_next.capture_clock_assign_lo |=> &capture_use_b;
	endproperty
	a_assign_all: assert property (p_assign_all) else $error("All-units assignment wrong.");

	property p_assign_none;
		wr_ctrl && !ctrl_next.capture_clock_assign_lo |=> capture_use_b == '0;
	endproperty
	a_assign_none: assert property (p_assign_none) else $error("First-pair assignment wrong.");

	property p_ext_direct;
		ctrl_reg.clock_source_select && ctrl_reg.sync_disable |-> ext_level == external_count_pin;
	endproperty
	a_ext_direct: assert property (p_ext_direct) else $error("Synchronizer not bypassed.");

	property p_int_src;
		ctrl_reg.timer_on && !ctrl_reg.clock_source_select |-> src_tick == int_tick;
	endproperty
	a_int_src: assert property (p_int_src) else $error("Internal source not used.");

	property p_inc_step;
		inc_tick && ctrl_reg.timer_on && !wr_lo && !wr_hi && !special_event |=> count_reg == $past(count_reg) + 16'h0001;
	endproperty
	a_inc_step: assert property (p_inc_step) else $error("Count did not step by one.");

	property p_w1c;
		wr_st && bus_wdata[`TBC_ST_OVF] && !overflow |=> !status_reg[`TBC_ST_OVF];
	endproperty
	a_w1c: assert property (p_w1c) else $error("Overflow flag not cleared by a one.");

	property p_set_wins;
		overflow |=> status_reg[`TBC_ST_OVF];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Overflow flag lost to a clear.");

	c_overflow: cover property (overflow ##1 irq);
	c_wide_read: cover property (rd_lo && ctrl_reg.wide_access_enable ##1 bus_rd && bus_addr == `TBC_OFF_CNT_HI);
	c_ext_count: cover property (ctrl_reg.clock_source_select && inc_tick);
	c_trigger: cover property (special_event ##1 count_reg == `TBC_CNT_RST);
	c_split_assign: cover property (wr_ctrl && !ctrl_next.capture_clock_assign_hi && ctrl_next.capture_clock_assign_lo);

endmodule : tbc_timer
`default_nettype wire

/* File: verif/tbc_pin_model.sv */
// Behavioural model of the external count source feeding the timer's count pin.
// Assumes sys_clk is the timer clock; the source runs only while enable is high.
`timescale 1ns/100ps
`default_nettype none

module tbc_pin_model (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       enable,
	input  wire logic [7:0] half,
	output logic            pin,
	output int              rises
);
	int ticks;

	// ----------------------------------------------------------------
	// Square-wave source
	// ----------------------------------------------------------------
	// The level stands still while disabled, like an oscillator gated off between bursts.
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pin   <= 1'b0;
			ticks <= 0;
			rises <= 0;
		end else if (enable) begin
			if (ticks + 1 >= half) begin
				ticks <= 0;
				pin   <= ~pin;
				if (!pin) begin
					rises <= rises + 1;  // Every rising edge is counted here; the bench works out which ones qualify.
				end
			end else begin
				ticks <= ticks + 1;
			end
		end
	end
endmodule : tbc_pin_model

`default_nettype wire

/* File: verif/tb_tbc_timer.sv */
// Self-checking bench for the sixteen-bit timer/counter.
// Assumes the register port of tbc_timer and the pin model in tbc_pin_model.sv.
`timescale 1ns/100ps
`default_nettype none
`include "tbc_defs.svh"

module tb_tbc_timer;
	localparam int NU = 5;
	logic                   sys_clk, reset, bus_wr, bus_rd, special_event, irq, src_en;
	logic [`TBC_ADDR_W-1:0] bus_addr;
	logic [7:0]             bus_wdata, bus_rdata, d;
	logic [NU-1:0]          capture_use_b;
	logic                   pin;
	logic [15:0]            cnt;
	int                     rises, r0, miscompares, n_tests;

	tbc_timer #(.CAPTURE_UNITS(NU)) uut (.sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.external_count_pin(pin), .special_event(special_event), .irq(irq), .capture_use_b(capture_use_b));
	tbc_pin_model src (.sys_clk(sys_clk), .reset(reset), .enable(src_en), .half(8'h03), .pin(pin), .rises(rises));

	// ----------------------------------------------------------------
	// Clock, watchdog and verdict
	// ----------------------------------------------------------------
	// Clock at 250 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// The full run takes about 1750 cycles, so 100 us means a hang.
	initial begin
		#100000;
		miscompares = miscompares + 1;
		test_done();
	end

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d.", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		bus_wr    <= 1'b1;
		bus_addr  <= a;
		bus_wdata <= v;
		@(posedge sys_clk);
		bus_wr    <= 1'b0;
	endtask : wr

	// Read data are taken in the one cycle after the read edge, their only valid cycle.
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		bus_rd   <= 1'b1;
		bus_addr <= a;
		@(posedge sys_clk);
		bus_rd   <= 1'b0;
		#1 v = bus_rdata;
	endtask : rd

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_tests = n_tests + 1;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			miscompares = miscompares + 1;
		end
	endtask : chk

	// Counts from a running clock depend on phase, so a small window is allowed.
	task automatic chk_near(input string n, input int e, input logic [15:0] g);
		n_tests = n_tests + 1;
		if ($isunknown(g) || int'(g) < e - 2 || int'(g) > e + 2) begin
			$display("ERROR %s expected %0d seen %0d", n, e, g);
			miscompares = miscompares + 1;
		end
	endtask : chk_near

	// Split-mode count access: high byte first so the low write lands last.
	task automatic set_cnt(input logic [15:0] v);
		wr(`TBC_OFF_CNT_HI, v[15:8]);
		wr(`TBC_OFF_CNT_LO, v[7:0]);
	endtask : set_cnt

	task automatic get_cnt(output logic [15:0] v);
		rd(`TBC_OFF_CNT_LO, v[7:0]);
		rd(`TBC_OFF_CNT_HI, v[15:8]);
	endtask : get_cnt

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] ccodes [4];
		logic [4:0] cexp [4];
		ccodes = '{8'h00, 8'h08, 8'h48, 8'h40};  // The last code, 10, is taken as 00.
		cexp   = '{5'b00000, 5'b11110, 5'b11111, 5'b00000};
		miscompares = 0;
		n_tests = 0;
		reset = 1'b1;
		{bus_wr, bus_rd, special_event, src_en} = 4'h0;
		bus_addr  = 3'h0;
		bus_wdata = 8'h00;
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		// Reset values and an unmapped address.
		rd(`TBC_OFF_CTRL, d);   chk("ctrl_rst", 16'h0000, {8'h00, d});
		get_cnt(cnt);           chk("cnt_rst", 16'h0000, cnt);
		rd(3'h6, d);            chk("unmapped", 16'h0000, {8'h00, d});
		// Capture clock assignment codes, with control readback.
		for (int i = 0; i < 4; i++) begin
			wr(`TBC_OFF_CTRL, ccodes[i]);
			rd(`TBC_OFF_CTRL, d); chk("ctrl_rb", {8'h00, ccodes[i]}, {8'h00, d});
			chk("assign", {11'h000, cexp[i]}, {11'h000, capture_use_b});
		end
		// Prescale codes on the internal clock: 256 cycles give 64 ticks before division.
		for (int p = 0; p < 4; p++) begin
			wr(`TBC_OFF_CTRL, 8'h00);
			set_cnt(16'h0000);
			wr(`TBC_OFF_CTRL, {2'b00, p[1:0], 4'h1});
			repeat (256) @(posedge sys_clk);
			wr(`TBC_OFF_CTRL, 8'h00);
			get_cnt(cnt); chk_near("prescale", 64 >> p, cnt);
			repeat (20) @(posedge sys_clk);
			get_cnt(r0[15:0]); chk("held_off", cnt, r0[15:0]);
		end
		// Internal source with sync-disable set, while the pin toggles.
		set_cnt(16'h0000);
		wr(`TBC_OFF_CTRL, 8'h05);
		src_en <= 1'b1;
		repeat (256) @(posedge sys_clk);
		wr(`TBC_OFF_CTRL, 8'h00);
		src_en <= 1'b0;
		get_cnt(cnt); chk_near("int_sync_ign", 64, cnt);
		// External source, synchronized and not: the first edge is a rise and must be skipped.
		for (int s = 0; s < 2; s++) begin
			wr(`TBC_OFF_CTRL, 8'h00);
			set_cnt(16'h0000);
			// The bench clock is not taken from the shared oscillator, so sync-disable is usable here.
			wr(`TBC_OFF_CTRL, s ? 8'h07 : 8'h03);
			r0 = rises;
			src_en <= 1'b1;
			repeat (60) @(posedge sys_clk);
			src_en <= 1'b0;
			repeat (10) @(posedge sys_clk);
			get_cnt(cnt); chk("ext_edges", 16'(rises - r0 - 1), cnt);
		end
		// Overflow with the interrupt unmasked, then cleared by writing one.
		wr(`TBC_OFF_CTRL, 8'h00);
		wr(`TBC_OFF_MASK, 8'h01);
		set_cnt(16'hfffe);
		wr(`TBC_OFF_CTRL, 8'h01);
		for (int k = 0; k < 100 && irq !== 1'b1; k++) @(posedge sys_clk);
		chk("irq_set", 16'h0001, {15'h0, irq});
		wr(`TBC_OFF_CTRL, 8'h00);
		rd(`TBC_OFF_STATUS, d); chk("ovf_flag", 16'h0001, {8'h00, d});
		wr(`TBC_OFF_STATUS, 8'h01);
		@(posedge sys_clk); #1;
		chk("irq_clr", 16'h0000, {15'h0, irq});
		// Overflow while masked: the flag sets, the output stays low.
		wr(`TBC_OFF_MASK, 8'h00);
		set_cnt(16'hffff);
		wr(`TBC_OFF_CTRL, 8'h01);
		repeat (40) @(posedge sys_clk);
		wr(`TBC_OFF_CTRL, 8'h00);
		rd(`TBC_OFF_STATUS, d); chk("ovf_masked", 16'h0001, {8'h00, d});
		chk("irq_masked", 16'h0000, {15'h0, irq});
		wr(`TBC_OFF_STATUS, 8'h01);
		// Wide mode: the high write waits in the buffer until the low write.
		wr(`TBC_OFF_CTRL, 8'h80);
		set_cnt(16'h0000);
		wr(`TBC_OFF_CNT_HI, 8'h12);
		get_cnt(cnt); chk("wide_hi_buffered", 16'h0000, cnt);
		// The low-byte read above refilled the shared buffer, so the high byte goes in again.
		wr(`TBC_OFF_CNT_HI, 8'h12);
		wr(`TBC_OFF_CNT_LO, 8'h34);
		get_cnt(cnt); chk("wide_load", 16'h1234, cnt);
		// Split mode: each byte goes straight to the count.
		wr(`TBC_OFF_CTRL, 8'h00);
		wr(`TBC_OFF_CNT_HI, 8'h56);
		get_cnt(cnt); chk("split_hi", 16'h5634, cnt);
		// Special event trigger clears the count.
		@(posedge sys_clk);
		special_event <= 1'b1;
		@(posedge sys_clk);
		special_event <= 1'b0;
		get_cnt(cnt); chk("special_event", 16'h0000, cnt);
		test_done();
	end
endmodule : tb_tbc_timer

`default_nettype wire
